// File: design/fkm_defs.vh
// constants for the flash key and margin command sequencer
`ifndef FKM_DEFS_VH
`define FKM_DEFS_VH

// register byte offsets on the bus
`define FKM_OFF_STAT 8'h00
`define FKM_OFF_IDX 8'h04
`define FKM_OFF_CCOB 8'h08
`define FKM_OFF_SEC 8'h0C
`define FKM_OFF_CFG 8'h10
`define FKM_OFF_MRG 8'h14

// flash_status_register bit positions
`define FKM_ST_CMD_COMPLETE_FLAG 7
`define FKM_ST_ACCESS_ERROR_FLAG 5
`define FKM_ST_PROTECTION_VIOLATION_FLAG 4
`define FKM_ST_MG1 1
`define FKM_ST_MG0 0

// security_register layout and reset value
`define FKM_SEC_KEY_ENABLE_FIELD_HI 7
`define FKM_SEC_KEY_ENABLE_FIELD_LO 6
`define FKM_SEC_RESET 8'h00
`define FKM_KEY_ENABLE_FIELD_ON 2'h2

// command codes and launch indices
`define FKM_CMD_KEY 8'h0C
`define FKM_CMD_UMRG 8'h0D
`define FKM_CMD_FMRG 8'h0E
`define FKM_IDX_KEY 3'h4
`define FKM_IDX_MRG 3'h1

// margin settings
`define FKM_MRG_NORMAL 16'h0000
`define FKM_MRG_USER_MAX 16'h0002
`define FKM_MRG_FIELD_MAX 16'h0004

// block select values of global address [17:16]
`define FKM_BLK_DF 2'h0
`define FKM_BLK_PF 2'h3

// stored backdoor comparison key location
`define FKM_KEY_BASE 18'h3FF00
`define FKM_KEY_STEP 18'h00002
`define FKM_KEY_LAST 3'h4

// bus responses
`define FKM_RESP_OKAY 2'h0
`define FKM_RESP_SLVERR 2'h2

`endif

// File: design/fkm_flash_cmd.v
// backdoor key and margin level command sequencer with an AXI4-Lite slave
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "fkm_defs.vh"

module fkm_flash_cmd #(
  parameter ADDR_W = 8,
  parameter CMD_DEPTH = 6
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write address channel
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address channel
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // stored comparison key port, data one cycle after address
  output reg [17:0] key_rd_addr,
  input wire [15:0] key_rd_data,
  // margin levels and security state toward the read path
  output reg [2:0] pflash_margin,
  output reg [2:0] dflash_margin,
  output reg security_open
);

  // one-hot sequencer states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_KEY = 3'b100;

  // merge new bus data into an old value under the byte strobes
  function [31:0] strb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
      strb_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strb_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // latched write request
  reg [ADDR_W-1:0] aw_addr_r; // held write address
  reg [31:0] w_data_r; // held write data
  reg [3:0] w_strb_r; // held write strobes
  wire wr_do; // both halves held, response slot free

  // software-visible state
  reg cmd_complete_flag_r; // high while idle, low while a command runs
  reg access_error_flag_r; // sticky, write one to clear
  reg [2:0] cmd_object_index_r; // selects the command-object word
  reg [15:0] cmd_object_r [0:CMD_DEPTH-1]; // command-object words
  reg [7:0] security_register_r; // key enable field lives here
  reg special_mode_r; // operating mode, special when high
  reg [31:0] rd_word; // read mux output

  // sequencer state
  reg [2:0] state_r; // one-hot state
  reg [2:0] key_cnt_r; // key compare step
  reg key_bad_r; // any key differed in this attempt
  reg key_mismatch_r; // a past attempt failed, cleared by reset only

  // decoded launch fields
  wire [7:0] cmd_code;
  wire [1:0] blk_sel;
  wire [15:0] mrg_set;
  wire blk_ok;
  wire key_allowed;
  wire is_field;
  wire mrg_ok;
  wire [2:0] mrg_lvl;
  wire [31:0] mw; // plain register write data under the byte strobes
  wire [31:0] ccob_mw; // selected command-object word merged with the new bytes

  // a write commits once both halves are held and no answer is pending; the
  // commit and bvalid rise on one edge, so a read issued after the answer sees it
  assign wr_do = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  // merged write words; the command-object merge keeps the unstrobed byte of the
  // selected word, so a narrow write does not wipe the other half
  assign mw = strb_merge(32'h00000000, w_data_r, w_strb_r);
  assign ccob_mw = strb_merge({16'h0000, cmd_object_r[cmd_object_index_r]},
                              w_data_r, w_strb_r);
  assign cmd_code = cmd_object_r[0][15:8];
  assign blk_sel = cmd_object_r[0][1:0];
  assign mrg_set = cmd_object_r[1];
  assign blk_ok = (blk_sel == `FKM_BLK_DF) || (blk_sel == `FKM_BLK_PF);
  assign is_field = (cmd_code == `FKM_CMD_FMRG);
  assign mrg_lvl = mrg_set[2:0];
  // user settings stop at 2, field settings reach 4
  assign mrg_ok = is_field ? (mrg_set <= `FKM_MRG_FIELD_MAX) :
                  (mrg_set <= `FKM_MRG_USER_MAX);
  // backdoor needs enable field at binary 10 and no earlier mismatch
  assign key_allowed = (security_register_r[`FKM_SEC_KEY_ENABLE_FIELD_HI:`FKM_SEC_KEY_ENABLE_FIELD_LO]
                        == `FKM_KEY_ENABLE_FIELD_ON) && ~key_mismatch_r;

  // write and read channel handshakes; each channel held until its partner arrives
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FKM_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `FKM_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      aw_addr_r <= {ADDR_W{1'b0}};
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else begin
      // take write address
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      // take write data
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // commit write and answer; unmapped offsets answer slave error
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr_r)
          `FKM_OFF_STAT, `FKM_OFF_IDX, `FKM_OFF_CCOB, `FKM_OFF_SEC, `FKM_OFF_CFG,
          `FKM_OFF_MRG: begin
            s_axi_bresp <= `FKM_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `FKM_RESP_SLVERR;
          end
        endcase
      end
      // response taken, reopen both write channels
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      // read address taken, data and rvalid registered on that same edge
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        case (s_axi_araddr)
          `FKM_OFF_STAT, `FKM_OFF_IDX, `FKM_OFF_CCOB, `FKM_OFF_SEC, `FKM_OFF_CFG,
          `FKM_OFF_MRG: begin
            s_axi_rresp <= `FKM_RESP_OKAY;
          end
          default: begin
            s_axi_rresp <= `FKM_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // read mux; unmapped offsets and reserved bits read zero
  // the mux follows araddr directly; rdata is captured on the address edge
  always @* begin
    rd_word = 32'h00000000;
    case (s_axi_araddr)
      `FKM_OFF_STAT: begin
        // protection and verify flags are never raised by these commands
        rd_word[`FKM_ST_CMD_COMPLETE_FLAG] = cmd_complete_flag_r;
        rd_word[`FKM_ST_ACCESS_ERROR_FLAG] = access_error_flag_r;
      end
      `FKM_OFF_IDX: begin
        rd_word[2:0] = cmd_object_index_r;
      end
      `FKM_OFF_CCOB: begin
        if (cmd_object_index_r < CMD_DEPTH) begin
          rd_word[15:0] = cmd_object_r[cmd_object_index_r];
        end
      end
      `FKM_OFF_SEC: begin
        rd_word[7:0] = security_register_r;
      end
      `FKM_OFF_CFG: begin
        rd_word[0] = special_mode_r;
      end
      `FKM_OFF_MRG: begin
        // live margin and security state
        rd_word[2:0] = pflash_margin;
        rd_word[6:4] = dflash_margin;
        rd_word[8] = security_open;
        rd_word[9] = key_mismatch_r;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // register writes and the command sequencer; later sequencer sets override
  // same-cycle software clears, so a flag raised as it is cleared is kept
  always @(posedge aclk) begin : seq
    integer k;
    if (!aresetn) begin
      state_r <= ST_IDLE;
      cmd_complete_flag_r <= 1'b1;
      access_error_flag_r <= 1'b0;
      cmd_object_index_r <= 3'h0;
      for (k = 0; k < CMD_DEPTH; k = k + 1) begin
        cmd_object_r[k] <= 16'h0000;
      end
      security_register_r <= `FKM_SEC_RESET;
      special_mode_r <= 1'b0;
      key_cnt_r <= 3'h0;
      key_bad_r <= 1'b0;
      key_mismatch_r <= 1'b0;
      key_rd_addr <= `FKM_KEY_BASE;
      pflash_margin <= 3'h0;
      dflash_margin <= 3'h0;
      security_open <= 1'b0;
    end else begin
      // software writes; parameters freeze while a command runs
      if (wr_do) begin
        case (aw_addr_r)
          `FKM_OFF_STAT: begin
            if (w_strb_r[0] && w_data_r[`FKM_ST_ACCESS_ERROR_FLAG]) begin
              access_error_flag_r <= 1'b0;
            end
            // clearing the complete flag launches the loaded command
            // launch needs the idle state as well as the flag, so a stray write of
            // one during a running command cannot restart it
            if (w_strb_r[0] && w_data_r[`FKM_ST_CMD_COMPLETE_FLAG] && cmd_complete_flag_r &&
                state_r == ST_IDLE) begin
              cmd_complete_flag_r <= 1'b0;
              state_r <= ST_EXEC;
            end
          end
          `FKM_OFF_IDX: begin
            if (state_r == ST_IDLE && w_strb_r[0]) begin
              cmd_object_index_r <= w_data_r[2:0];
            end
          end
          `FKM_OFF_CCOB: begin
            if (state_r == ST_IDLE && cmd_object_index_r < CMD_DEPTH) begin
              cmd_object_r[cmd_object_index_r] <= ccob_mw[15:0];
            end
          end
          `FKM_OFF_SEC: begin
            if (w_strb_r[0]) begin
              security_register_r <= mw[7:0];
            end
          end
          `FKM_OFF_CFG: begin
            if (w_strb_r[0]) begin
              special_mode_r <= mw[0];
            end
          end
          default: begin
            special_mode_r <= special_mode_r;
          end
        endcase
      end
      case (state_r)
        ST_IDLE: begin
          key_cnt_r <= 3'h0;
        end
        ST_EXEC: begin
          // checks run in the cycle after launch, then complete unless an accepted key command moves on to the key compare
          state_r <= ST_IDLE;
          cmd_complete_flag_r <= 1'b1;
          case (cmd_code)
            `FKM_CMD_KEY: begin
              if (cmd_object_index_r != `FKM_IDX_KEY || !key_allowed) begin
                access_error_flag_r <= 1'b1;
              end else begin
                // start reading stored keys; completion waits for the compare
                state_r <= ST_KEY;
                cmd_complete_flag_r <= 1'b0;
                key_cnt_r <= 3'h0;
                key_bad_r <= 1'b0;
                key_rd_addr <= `FKM_KEY_BASE;
              end
            end
            `FKM_CMD_UMRG, `FKM_CMD_FMRG: begin
              if (cmd_object_index_r != `FKM_IDX_MRG || (is_field && !special_mode_r) ||
                  !mrg_ok || !blk_ok) begin
                access_error_flag_r <= 1'b1;
              end else if (blk_sel == `FKM_BLK_PF) begin
                // program block level also governs data block reads
                pflash_margin <= mrg_lvl;
                dflash_margin <= mrg_lvl;
              end else begin
                dflash_margin <= mrg_lvl;
              end
            end
            default: begin
              // other commands are served elsewhere; refuse them here
              access_error_flag_r <= 1'b1;
            end
          endcase
        end
        ST_KEY: begin
          // key_rd_data holds stored key (cnt-1); compare with object word cnt
          // the walk issues one fetch past the last word; its data is never compared
          key_cnt_r <= key_cnt_r + 3'h1;
          key_rd_addr <= key_rd_addr + `FKM_KEY_STEP;
          if (key_cnt_r != 3'h0 && key_rd_data != cmd_object_r[key_cnt_r]) begin
            key_bad_r <= 1'b1;
          end
          if (key_cnt_r == `FKM_KEY_LAST) begin
            state_r <= ST_IDLE;
            cmd_complete_flag_r <= 1'b1;
            key_rd_addr <= `FKM_KEY_BASE;
            if (key_bad_r || key_rd_data != cmd_object_r[key_cnt_r]) begin
              // a failed attempt locks out the backdoor until reset
              key_mismatch_r <= 1'b1;
              access_error_flag_r <= 1'b1;
            end else begin
              security_open <= 1'b1;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: verif/fkm_flash_cmd_asserts.sv
// port checks for the flash key and margin sequencer
`timescale 1ns/1ps
module fkm_flash_cmd_chk (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // key fetch and read path
  input wire [17:0] key_rd_addr,
  input wire [2:0] pflash_margin,
  input wire [2:0] dflash_margin,
  input wire security_open
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // both write halves taken on one edge: channels close, the answer follows an edge later
  a_b_after_take: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid)
    else $error("no write answer");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not freed");
  a_r_after_take: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read not freed");
  // stored key words are fetched in ascending order
  a_key_walk: assert property (key_rd_addr == 18'h3FF02 |=> key_rd_addr == 18'h3FF04
    ##1 key_rd_addr == 18'h3FF06) else $error("key fetch order");
  // security opens only after the last key word was fetched
  a_open_walk: assert property ($rose(security_open) |-> $past(key_rd_addr, 2) == 18'h3FF06)
    else $error("security opened early");
  a_open_sticky: assert property (security_open |=> security_open)
    else $error("security closed");
  // margins move only as a command that was just committed completes
  a_margin_cause: assert property ($changed({pflash_margin, dflash_margin})
    |-> $past(s_axi_bvalid)) else $error("margin moved alone");
  // the program block always drags the data block along
  a_pf_both: assert property ($changed(pflash_margin) |-> dflash_margin == pflash_margin)
    else $error("program margin alone");
endmodule

bind fkm_flash_cmd fkm_flash_cmd_chk u_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .key_rd_addr(key_rd_addr), .pflash_margin(pflash_margin),
  .dflash_margin(dflash_margin), .security_open(security_open)
);

// File: verif/fkm_flash_cmd_tb.sv
// self-checking bench for the flash key and margin sequencer
`timescale 1ns/1ps
`include "fkm_defs.vh"
module fkm_flash_cmd_tb;
  // bus masters drive, answers always accepted
  reg aclk = 1'h0;
  reg aresetn = 1'h0;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg [7:0] s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg s_axi_awvalid = 1'h0;
  reg s_axi_wvalid = 1'h0;
  reg s_axi_arvalid = 1'h0;
  reg [15:0] key_rd_data = 16'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, security_open;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [17:0] key_rd_addr;
  wire [2:0] pflash_margin, dflash_margin;
  // bench state
  reg [15:0] prm [0:4];
  reg [1:0] resp_q;
  reg [31:0] d;
  integer k;
  integer err_count = 0;
  integer comparisons = 0;

  fkm_flash_cmd dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(1'h1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'h1),
    .key_rd_addr(key_rd_addr), .key_rd_data(key_rd_data),
    .pflash_margin(pflash_margin), .dflash_margin(dflash_margin), .security_open(security_open)
  );

  // 25 MHz clock
  always #20 aclk = ~aclk;

  // stored key words, a pattern of the address, one cycle late
  always @(posedge aclk) begin
    key_rd_data <= {8'hA5, key_rd_addr[7:0]};
  end

  task results;
    begin
      if (err_count == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // a wait that ran out ends the run
  task tmo;
    begin
      err_count = err_count + 1;
      $display("wrong value handshake expected done seen timeout");
      results;
    end
  endtask

  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task rst;
    begin
      aresetn <= 1'h0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
    end
  endtask

  // address and data offered together, each dropped once taken
  task wr(input [7:0] a, input [31:0] v);
    integer n;
    reg aw, w, fin;
    begin
      aw = 1'h1;
      w = 1'h1;
      fin = 1'h0;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      while (!fin) begin
        @(posedge aclk);
        n = n + 1;
        if (n > 40) tmo;
        if (!aw && !w && s_axi_bvalid) begin
          fin = 1'h1;
          resp_q = s_axi_bresp;
        end
        if (aw && s_axi_awready) begin
          aw = 1'h0;
          s_axi_awvalid <= 1'h0;
        end
        if (w && s_axi_wready) begin
          w = 1'h0;
          s_axi_wvalid <= 1'h0;
        end
      end
    end
  endtask

  task rd(input [7:0] a, output [31:0] v);
    integer n;
    reg ar, fin;
    begin
      ar = 1'h1;
      fin = 1'h0;
      n = 0;
      v = 32'h0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      while (!fin) begin
        @(posedge aclk);
        n = n + 1;
        if (n > 40) tmo;
        if (ar && s_axi_arready) begin
          ar = 1'h0;
          s_axi_arvalid <= 1'h0;
        end else if (!ar && s_axi_rvalid) begin
          fin = 1'h1;
          v = s_axi_rdata;
          resp_q = s_axi_rresp;
        end
      end
    end
  endtask

  // load indices 0..top, launch, poll the complete flag, then clear the error
  task cmd(input [15:0] w0, input [2:0] top, input err);
    integer i;
    reg [31:0] st;
    begin
      for (i = 0; i <= top; i = i + 1) begin
        wr(`FKM_OFF_IDX, i);
        wr(`FKM_OFF_CCOB, {16'h0, (i == 0) ? w0 : prm[i]});
      end
      wr(`FKM_OFF_STAT, 32'h80);
      st = 32'h0;
      i = 0;
      while (st[7] !== 1'h1) begin
        rd(`FKM_OFF_STAT, st);
        i = i + 1;
        if (i > 20) tmo;
      end
      chk("status", err ? 32'hA0 : 32'h80, st);
      wr(`FKM_OFF_STAT, 32'h20);
    end
  endtask

  // margin levels and security state, by register and at the pins
  task mchk(input [2:0] pf, input [2:0] df, input opn, input mis);
    reg [31:0] v;
    begin
      rd(`FKM_OFF_MRG, v);
      chk("margin register", {22'h0, mis, opn, 1'h0, df, 1'h0, pf}, v);
      chk("margin pins", {25'h0, opn, df, pf}, {25'h0, security_open, dflash_margin, pflash_margin});
    end
  endtask

  initial begin
    for (k = 0; k < 5; k = k + 1)
      prm[k] = 16'hA4FE + k[15:0] * 16'h2;
    rst;
    rd(`FKM_OFF_STAT, d);
    chk("idle status", 32'h80, d);
    mchk(3'h0, 3'h0, 1'h0, 1'h0);
    rd(8'h18, d);
    chk("unmapped resp", 32'h2, {30'h0, resp_q});
    wr(8'h18, 32'h1);
    chk("unmapped wr resp", 32'h2, {30'h0, resp_q});
    // user levels on the program block, then the data block alone
    for (k = 0; k < 3; k = k + 1) begin
      prm[1] = k[15:0];
      cmd(16'h0D03, 3'h1, 1'h0);
      mchk(k[2:0], k[2:0], 1'h0, 1'h0);
    end
    prm[1] = 16'h1;
    cmd(16'h0D00, 3'h1, 1'h0);
    mchk(3'h2, 3'h1, 1'h0, 1'h0);
    // refused: bad setting, bad blocks, no special mode, wrong index
    prm[1] = 16'h3;
    cmd(16'h0D03, 3'h1, 1'h1);
    prm[1] = 16'h1;
    cmd(16'h0D01, 3'h1, 1'h1);
    cmd(16'h0D02, 3'h1, 1'h1);
    cmd(16'h0E03, 3'h1, 1'h1);
    cmd(16'h0D03, 3'h2, 1'h1);
    // a code served elsewhere is refused by this sequencer
    cmd(16'h0900, 3'h0, 1'h1);
    mchk(3'h2, 3'h1, 1'h0, 1'h0);
    // field levels in special mode
    wr(`FKM_OFF_CFG, 32'h1);
    chk("write resp", 32'h0, {30'h0, resp_q});
    for (k = 3; k < 5; k = k + 1) begin
      prm[1] = k[15:0];
      cmd(16'h0E00, 3'h1, 1'h0);
      mchk(3'h2, k[2:0], 1'h0, 1'h0);
    end
    cmd(16'h0E03, 3'h1, 1'h0);
    mchk(3'h4, 3'h4, 1'h0, 1'h0);
    prm[1] = 16'h5;
    cmd(16'h0E03, 3'h1, 1'h1);
    // key command refused for every key enable value but binary 10
    prm[1] = 16'hA500;
    for (k = 0; k < 256; k = k + 64)
      if (k != 128) begin
        wr(`FKM_OFF_SEC, k);
        cmd(16'h0C00, 3'h4, 1'h1);
      end
    wr(`FKM_OFF_SEC, 32'h80);
    cmd(16'h0C00, 3'h3, 1'h1);
    mchk(3'h4, 3'h4, 1'h0, 1'h0);
    // a wrong key latches the mismatch, so a right one is refused later
    prm[3] = 16'h0;
    cmd(16'h0C00, 3'h4, 1'h1);
    prm[3] = 16'hA504;
    cmd(16'h0C00, 3'h4, 1'h1);
    mchk(3'h4, 3'h4, 1'h0, 1'h1);
    rst;
    rd(`FKM_OFF_SEC, d);
    chk("security reset", 32'h0, d);
    mchk(3'h0, 3'h0, 1'h0, 1'h0);
    wr(`FKM_OFF_SEC, 32'h80);
    // after reset, the right key with the enable field at binary 10 opens security
    cmd(16'h0C00, 3'h4, 1'h0);
    mchk(3'h0, 3'h0, 1'h1, 1'h0);
    results;
  end
endmodule
